//--- dv/serial_remote_tx.sv
/*
 Model of the remote serial transmitter feeding the receiver strobes.
 Assumes the bench calls its tasks on the shared clock.
*/
`timescale 1ns/10ps
module serial_remote_tx #(parameter int DIV = 4) (
   input wire logic clk_i,
   output logic rxd_o,
   output logic etu_o,
   output logic start_o,
   output logic valid_o,
   output logic [7:0] data_o,
   output logic fer_o,
   output logic per_o
);
   // ****************
   // Bit clock and frames
   // ****************
   int div_cnt = 0;
   initial begin
      {rxd_o, etu_o, start_o, valid_o, data_o, fer_o, per_o} = {4'h8, 8'hff, 2'h0};
   end
   always @(posedge clk_i) begin
      div_cnt <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
      etu_o <= (div_cnt == DIV - 1);
   end
   // Hold keeps the line at space, as a break does
   task automatic send(input logic [7:0] d, input logic f, input logic p, input logic hold);
      @(posedge clk_i);
      {start_o, rxd_o} <= 2'b10;
      @(posedge clk_i);
      start_o <= 1'b0;
      repeat (10 * DIV) @(posedge clk_i);
      {valid_o, data_o, fer_o, per_o} <= {1'b1, d, f, p};
      @(posedge clk_i);
      // Stale data is inverted so a late sample cannot match
      {valid_o, data_o, fer_o, per_o} <= {1'b0, ~d, ~f, ~p};
      rxd_o <= ~hold;
   endtask
   task automatic mark;
      @(posedge clk_i);
      rxd_o <= 1'b1;
   endtask
endmodule // serial_remote_tx

//--- dv/uart_fifo_status_flags_bench.sv
/*
 Self-checking bench for the status flag block.
 Assumes the remote transmitter model and the design package.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("Error %0t: got %h expected %h", $time, g, e); end end
module uart_fifo_status_flags_bench;
   localparam int ETU = 4;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, dma_rd, take, ack, dma_ack, tx_stb;
   logic rxd, etu, rstart, rvalid, rfer, rper;
   logic [7:0] adr, rdata, dma_dat, tx_dat;
   logic [31:0] wdat, rdat, q;
   int error_cnt = 0;
   int check_count = 0;
   int cyc_cnt = 0;
   uart_fifo_status_flags dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rxd_i(rxd), .etu_tick_i(etu), .rx_start_i(rstart), .rx_valid_i(rvalid),
      .rx_data_i(rdata), .rx_fer_i(rfer), .rx_per_i(rper), .tx_take_i(take), .tx_stb_o(tx_stb),
      .tx_data_o(tx_dat), .dma_rd_i(dma_rd), .dma_ack_o(dma_ack), .dma_data_o(dma_dat));
   serial_remote_tx #(.DIV(ETU)) rem (.clk_i(clk_i), .rxd_o(rxd), .etu_o(etu),
      .start_o(rstart), .valid_o(rvalid), .data_o(rdata), .fer_o(rfer), .per_o(rper));
   initial forever #10 clk_i = ~clk_i;
   // ****************
   // Bus tasks
   // ****************
   task automatic wr(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      @(posedge clk_i);
      // Request stands until the edge that samples ack high
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a);
      wr(1'b0, a, 32'h0);
   endtask
   task automatic dma;
      @(posedge clk_i);
      dma_rd <= 1'b1;
      @(posedge clk_i);
      while (dma_ack !== 1'b1) @(posedge clk_i);
      q = {24'h0, dma_dat};
      dma_rd <= 1'b0;
   endtask
   task automatic do_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   // ****************
   // Scenarios
   // ****************
   task automatic t_reset;
      do_reset();
      rd(flags_pkg::OFS_STAT); `CHK(q[5:0], 6'h20)
      rd(flags_pkg::OFS_CTRL); `CHK(q[7:4], 4'h0)
      rd(flags_pkg::OFS_CNT); `CHK({q[12:8], q[4:0]}, 10'h000)
   endtask
   task automatic t_thresh;
      logic [4:0] thr [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
      for (int c = 0; c < 4; c++) begin
         do_reset();
         wr(1'b1, flags_pkg::OFS_CTRL, 32'(c) << 6);
         for (int i = 1; i <= thr[c]; i++) begin
            rem.send(8'(i), 1'b0, 1'b0, 1'b0);
            rd(flags_pkg::OFS_STAT); `CHK(q[1], 1'(i == thr[c]))
         end
         rd(flags_pkg::OFS_CNT); `CHK(q[4:0], thr[c])
      end
   endtask
   task automatic t_errors;
      do_reset();
      wr(1'b1, flags_pkg::OFS_CTRL, 32'h40);
      rem.send(8'ha1, 1'b1, 1'b0, 1'b0);
      rem.send(8'ha2, 1'b0, 1'b1, 1'b0);
      rem.send(8'ha3, 1'b0, 1'b0, 1'b0);
      rem.send(8'ha4, 1'b1, 1'b1, 1'b0);
      rd(flags_pkg::OFS_STAT); `CHK(q[5:1], 5'h15)
      // Clear before draining must not stick while still at threshold
      wr(1'b1, flags_pkg::OFS_STAT, 32'h0);
      rd(flags_pkg::OFS_STAT); `CHK(q[1], 1'b1)
      rd(flags_pkg::OFS_RXD); `CHK(q[7:0], 8'ha1)
      rd(flags_pkg::OFS_STAT); `CHK(q[3:1], 3'b011)
      wr(1'b1, flags_pkg::OFS_STAT, 32'h0);
      rd(flags_pkg::OFS_STAT); `CHK(q[3:1], 3'b010)
      rd(flags_pkg::OFS_RXD);
      rd(flags_pkg::OFS_RXD); `CHK(q[7:0], 8'ha3)
      rd(flags_pkg::OFS_STAT); `CHK(q[3:2], 2'b11)
      rd(flags_pkg::OFS_CNT); `CHK(q[4:0], 5'h01)
   endtask
   task automatic t_idle;
      do_reset();
      wr(1'b1, flags_pkg::OFS_CTRL, 32'h40);
      rem.send(8'h5a, 1'b0, 1'b0, 1'b0);
      repeat (13 * ETU) @(posedge clk_i);
      rd(flags_pkg::OFS_STAT); `CHK(q[0], 1'b0)
      repeat (3 * ETU) @(posedge clk_i);
      rd(flags_pkg::OFS_STAT); `CHK(q[1:0], 2'b01)
      dma(); `CHK(q[7:0], 8'h5a)
      rd(flags_pkg::OFS_STAT); `CHK(q[0], 1'b0)
      rem.send(8'h66, 1'b0, 1'b0, 1'b0);
      repeat (16 * ETU) @(posedge clk_i);
      rd(flags_pkg::OFS_STAT); `CHK(q[0], 1'b1)
      // Clear while a byte remains must not take
      wr(1'b1, flags_pkg::OFS_STAT, 32'h0);
      rd(flags_pkg::OFS_STAT); `CHK(q[0], 1'b1)
      rd(flags_pkg::OFS_RXD); `CHK(q[7:0], 8'h66)
      wr(1'b1, flags_pkg::OFS_STAT, 32'h0);
      rd(flags_pkg::OFS_STAT); `CHK(q[0], 1'b0)
   endtask
   task automatic t_break;
      do_reset();
      rem.send(8'h00, 1'b1, 1'b0, 1'b1);
      repeat (12 * ETU) @(posedge clk_i);
      wr(1'b1, flags_pkg::OFS_STAT, 32'h0);
      rd(flags_pkg::OFS_STAT); `CHK(q[4], 1'b1)
      wr(1'b1, flags_pkg::OFS_STAT, 32'h0);
      rd(flags_pkg::OFS_STAT); `CHK(q[4], 1'b0)
      rem.send(8'h00, 1'b1, 1'b0, 1'b1);
      rd(flags_pkg::OFS_CNT); `CHK(q[4:0], 5'h01)
      rem.mark();
      rem.send(8'h33, 1'b0, 1'b0, 1'b0);
      rd(flags_pkg::OFS_CNT); `CHK(q[4:0], 5'h02)
   endtask
   task automatic t_tx;
      // Room is a level: once it drops the limit lapses and the fifo fills
      logic [4:0] lim [4] = '{5'h08, 5'h10, 5'h10, 5'h10};
      for (int c = 0; c < 4; c++) begin
         do_reset();
         wr(1'b1, flags_pkg::OFS_CTRL, 32'(c) << 4);
         for (int i = 0; i < 17; i++) wr(1'b1, flags_pkg::OFS_TXD, 32'(i));
         rd(flags_pkg::OFS_CNT); `CHK(q[12:8], lim[c])
         rd(flags_pkg::OFS_STAT); `CHK(q[5], 1'(c == 0))
         @(posedge clk_i);
         take <= 1'b1;
         @(posedge clk_i);
         take <= 1'b0;
         @(posedge clk_i);
         `CHK({tx_stb, tx_dat}, 9'h100)
         rd(flags_pkg::OFS_CNT); `CHK(q[12:8], lim[c] - 5'h01)
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Ceiling well above the roughly 2300 cycles of the run
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial begin
      {cyc, stb, we, dma_rd, take, adr, wdat} = 45'h0;
      t_reset();
      t_thresh();
      t_errors();
      t_idle();
      t_break();
      t_tx();
      report_and_stop();
   end
endmodule // uart_fifo_status_flags_bench

//--- hdl/flags_pkg.sv
/*
 Constants, register map and carrier types for the serial status flag block.
 Assumes a Wishbone classic slave port and a receiver and transmitter on the same clock.
*/
//
// Contract
// - While tx room is set, accept at most 16 minus tx threshold more bytes.
// - Transmit fifo byte count appears in the upper field of the count register.
// - Framing error then space for one frame length sets the break flag.
// - Break flag clears only by writing 0 after reading 1, or reset.
// - During a break, zero characters are not stored; storing resumes at mark.
// - Framing fault flag shows the error tag of the receive fifo head byte.
// - Parity fault flag shows the error tag of the receive fifo head byte.
// - Rx fill flag sets while receive count is at or above the threshold.
// - DMA draining below threshold clears rx fill without a software write.
// - Receive fifo holds 16 bytes; reading it empty returns undefined data.
// - Receive fifo byte count appears in the lower field of the count register.
// - Idle data flag sets when count below threshold and 15 bit times idle.
// - DMA draining the receive fifo empty clears the idle data flag.
// - Idle timeout counts bit periods at the current baud rate.
// - Reset clears break, framing, parity, rx fill and idle data flags.
// - Rx threshold codes 0..3 select 1, 4, 8, 14 bytes; reset code 0.
// - Tx threshold codes 0..3 select 8, 4, 2, 1; room set at or below.
package flags_pkg;
   // ****************
   // Register map
   // ****************
   localparam logic [7:0] OFS_STAT = 8'h00;
   localparam logic [7:0] OFS_TXD = 8'h04;
   localparam logic [7:0] OFS_RXD = 8'h08;
   localparam logic [7:0] OFS_CNT = 8'h0c;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam int B_DR = 0;
   localparam int B_RDF = 1;
   localparam int B_PER = 2;
   localparam int B_FER = 3;
   localparam int B_BRK = 4;
   localparam int B_ROOM = 5;
   localparam int B_TTRG = 4;
   localparam int B_RTRG = 6;
   localparam int B_TXCNT = 8;
   // ****************
   // Sizes, thresholds and timing
   // ****************
   localparam logic [4:0] DEPTH = 5'h10;
   localparam logic [3:0][4:0] RX_THR = {5'h0e, 5'h08, 5'h04, 5'h01};
   localparam logic [3:0][4:0] TX_THR = {5'h01, 5'h02, 5'h04, 5'h08};
   localparam logic [3:0] IDLE_ETU = 4'hf;
   localparam logic [3:0] FRAME_ETU = 4'ha;
   localparam logic [1:0] RTRG_RST = 2'h0;
   localparam logic [1:0] TTRG_RST = 2'h0;
   typedef struct packed {
      logic framing_fault_flag;
      logic parity_fault_flag;
      logic [7:0] data;
   } rx_entry_t;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
      logic s1;
      logic s2;
      logic [15:0][7:0] txm;
      logic [3:0] tx_wp;
      logic [3:0] tx_rp;
      logic [4:0] tx_cnt;
      logic [4:0] tx_acc;
      logic room;
      logic tx_stb;
      logic [7:0] tx_dat;
      logic [15:0] rxm_unused;
      logic [3:0] rx_wp;
      logic [3:0] rx_rp;
      logic [4:0] rx_cnt;
      logic line_break_flag;
      logic brk_seen;
      logic rx_fill_flag;
      logic rdf_seen;
      logic dr;
      logic dr_seen;
      logic [3:0] idle;
      logic idle_run;
      logic arm;
      logic [3:0] bcnt;
      logic bact;
      logic [1:0] rtrg;
      logic [1:0] ttrg;
      logic dma_ack;
      logic [7:0] dma_dat;
   } state_t;
endpackage

//--- hdl/uart_fifo_status_flags.sv
/*
 Status flags, 16-byte transmit and receive fifos and Wishbone register slave.
 Assumes receiver and transmitter on clk_i give char and bit-period strobes.
*/
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
module uart_fifo_status_flags (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rxd_i,
   input wire logic etu_tick_i,
   input wire logic rx_start_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_fer_i,
   input wire logic rx_per_i,
   input wire logic tx_take_i,
   output logic tx_stb_o,
   output logic [7:0] tx_data_o,
   input wire logic dma_rd_i,
   output logic dma_ack_o,
   output logic [7:0] dma_data_o
);
   flags_pkg::state_t r;
   flags_pkg::state_t n;
   flags_pkg::rx_entry_t rxm_r [16];
   flags_pkg::rx_entry_t head;
   logic [4:0] rxthr;
   logic [4:0] txthr;
   logic req;
   logic wr_stat;
   logic cpu_pop;
   logic dma_pop;
   logic push;
   logic tx_acc_ok;
   logic tx_push;
   logic tx_pop;
   logic fer_w;
   logic per_w;
   logic [15:0] stat_w;

   // ****************
   // Next state
   // ****************
   always_comb begin
      n = r;
      head = rxm_r[r.rx_rp];
      rxthr = flags_pkg::RX_THR[r.rtrg];
      txthr = flags_pkg::TX_THR[r.ttrg];
      fer_w = (r.rx_cnt != 5'h00) & head.framing_fault_flag;
      per_w = (r.rx_cnt != 5'h00) & head.parity_fault_flag;
      stat_w = {10'h000, r.room, r.line_break_flag, fer_w, per_w, r.rx_fill_flag, r.dr};
      n.s1 = rxd_i;
      n.s2 = r.s1;
      n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
      req = n.ack;
      wr_stat = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == flags_pkg::OFS_STAT);
      // Empty reads still answer with the stale head entry
      cpu_pop = req & ~wb_we_i & (wb_adr_i == flags_pkg::OFS_RXD)
         & (r.rx_cnt != 5'h00);
      n.dma_ack = dma_rd_i & ~r.dma_ack & ~cpu_pop;
      dma_pop = n.dma_ack & (r.rx_cnt != 5'h00);
      if (n.dma_ack) begin
         n.dma_dat = head.data;
      end
      // Zero characters inside a break never reach the fifo
      push = rx_valid_i & ~(r.bact & (rx_data_i == 8'h00))
         & (r.rx_cnt != flags_pkg::DEPTH);
      n.rx_cnt = r.rx_cnt + 5'(push) - 5'(cpu_pop | dma_pop);
      if (push) begin
         n.rx_wp = r.rx_wp + 4'h1;
      end
      if (cpu_pop | dma_pop) begin
         n.rx_rp = r.rx_rp + 4'h1;
      end
      // Transmit fifo with write limit while room is reported
      tx_acc_ok = ~r.room | (r.tx_acc < (flags_pkg::DEPTH - txthr));
      tx_push = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == flags_pkg::OFS_TXD)
         & (r.tx_cnt != flags_pkg::DEPTH) & tx_acc_ok;
      tx_pop = tx_take_i & (r.tx_cnt != 5'h00);
      n.tx_stb = tx_pop;
      if (tx_pop) begin
         n.tx_dat = r.txm[r.tx_rp];
         n.tx_rp = r.tx_rp + 4'h1;
      end
      if (tx_push) begin
         n.txm[r.tx_wp] = wb_dat_i[7:0];
         n.tx_wp = r.tx_wp + 4'h1;
      end
      n.tx_cnt = r.tx_cnt + 5'(tx_push) - 5'(tx_pop);
      n.room = (n.tx_cnt <= txthr);
      if (n.room & ~r.room) begin
         n.tx_acc = 5'h00;
      end else if (tx_push & r.room) begin
         n.tx_acc = r.tx_acc + 5'h01;
      end
      // Register reads and control writes
      n.dat = 32'h0000_0000;
      if (req & ~wb_we_i) begin
         case (wb_adr_i)
            flags_pkg::OFS_STAT: n.dat = {16'h0000, stat_w};
            flags_pkg::OFS_RXD: n.dat = {24'h00_0000, head.data};
            flags_pkg::OFS_CNT: n.dat = {19'h0_0000, r.tx_cnt, 3'h0, r.rx_cnt};
            flags_pkg::OFS_CTRL: n.dat = {24'h00_0000, r.rtrg, r.ttrg, 4'h0};
            default: n.dat = 32'h0000_0000;
         endcase
         if (wb_adr_i == flags_pkg::OFS_STAT) begin
            n.brk_seen = r.brk_seen | r.line_break_flag;
            n.rdf_seen = r.rdf_seen | r.rx_fill_flag;
            n.dr_seen = r.dr_seen | r.dr;
         end
      end
      if (req & wb_we_i & wb_sel_i[0] & (wb_adr_i == flags_pkg::OFS_CTRL)) begin
         n.rtrg = wb_dat_i[flags_pkg::B_RTRG +: 2];
         n.ttrg = wb_dat_i[flags_pkg::B_TTRG +: 2];
      end
      // Break detection: counts bit periods of space after a framing error
      if (rx_valid_i & rx_fer_i) begin
         n.arm = 1'b1;
         n.bcnt = 4'h0;
      end else if (r.arm) begin
         if (r.s2) begin
            n.arm = 1'b0;
         end else if (etu_tick_i) begin
            n.bcnt = r.bcnt + 4'h1;
            if (r.bcnt == flags_pkg::FRAME_ETU - 4'h1) begin
               n.arm = 1'b0;
               n.bact = 1'b1;
            end
         end
      end
      if (r.bact & r.s2) begin
         n.bact = 1'b0;
      end
      // Clears first so that a coincident set wins
      if (wr_stat & ~wb_dat_i[flags_pkg::B_BRK] & r.brk_seen) begin
         n.line_break_flag = 1'b0;
         n.brk_seen = 1'b0;
      end
      if (n.bact & ~r.bact) begin
         n.line_break_flag = 1'b1;
         n.brk_seen = 1'b0;
      end
      if ((wr_stat & ~wb_dat_i[flags_pkg::B_RDF] & r.rdf_seen) | dma_pop) begin
         if (n.rx_cnt < rxthr) begin
            n.rx_fill_flag = 1'b0;
            n.rdf_seen = 1'b0;
         end
      end
      if ((n.rx_cnt >= rxthr) & ~r.rx_fill_flag) begin
         n.rx_fill_flag = 1'b1;
         n.rdf_seen = 1'b0;
      end
      // Idle timer in bit periods after the last stop bit
      if (rx_valid_i) begin
         n.idle = 4'h0;
         n.idle_run = 1'b1;
      end else if (rx_start_i) begin
         n.idle_run = 1'b0;
      end else if (r.idle_run & etu_tick_i) begin
         n.idle = r.idle + 4'h1;
         if (r.idle == flags_pkg::IDLE_ETU - 4'h1) begin
            n.idle_run = 1'b0;
         end
      end
      if ((wr_stat & ~wb_dat_i[flags_pkg::B_DR] & r.dr_seen) | dma_pop) begin
         if (n.rx_cnt == 5'h00) begin
            n.dr = 1'b0;
            n.dr_seen = 1'b0;
         end
      end
      if (r.idle_run & ~n.idle_run & ~rx_start_i & ~rx_valid_i
         & (n.rx_cnt < rxthr) & (n.rx_cnt != 5'h00)) begin
         n.dr = 1'b1;
         n.dr_seen = 1'b0;
      end
      n.rxm_unused = 16'h0000;
   end

   // ****************
   // State registers
   // ****************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= '0;
         r.room <= 1'b1;
         r.s1 <= 1'b1;
         r.s2 <= 1'b1;
         r.rtrg <= flags_pkg::RTRG_RST;
         r.ttrg <= flags_pkg::TTRG_RST;
      end else begin
         r <= n;
      end
   end

   // Entry array kept out of the reset path; tags ride with the data
   always_ff @(posedge clk_i) begin
      if (push) begin
         rxm_r[r.rx_wp] <= '{framing_fault_flag: rx_fer_i, parity_fault_flag: rx_per_i, data: rx_data_i};
      end
   end

   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;
   assign tx_stb_o = r.tx_stb;
   assign tx_data_o = r.tx_dat;
   assign dma_ack_o = r.dma_ack;
   assign dma_data_o = r.dma_dat;

   // ****************
   // Checks
   // ****************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (r.ack |=> !r.ack)
      else $error("ack held two cycles");
   a_rx_cap: assert property (r.rx_cnt <= flags_pkg::DEPTH)
      else $error("rx count above depth");
   a_tx_limit: assert property (r.room |-> r.tx_acc <= flags_pkg::DEPTH - txthr)
      else $error("tx writes beyond limit");
   a_brk_clear: assert property ($fell(r.line_break_flag) |-> $past(wr_stat && r.brk_seen))
      else $error("break cleared without write");
   a_brk_drop: assert property (r.bact && rx_valid_i && rx_data_i == 8'h00 |=>
      $stable(r.rx_wp)) else $error("zero stored during break");
   a_rdf_level: assert property (r.rx_cnt >= rxthr && $stable(r.rtrg) |-> r.rx_fill_flag)
      else $error("rx fill missing");
   a_dr_cond: assert property ($rose(r.dr) |-> r.rx_cnt != 5'h00 && r.rx_cnt < rxthr)
      else $error("idle data set wrongly");
   a_dma_empty: assert property (dma_pop && r.rx_cnt == 5'h01 |=> !r.dr)
      else $error("idle data kept after dma drain");
   a_fer_empty: assert property (r.rx_cnt == 5'h00 |-> !fer_w && !per_w)
      else $error("error flag with empty fifo");

   c_brk: cover property ($rose(r.line_break_flag));
   c_dr: cover property ($rose(r.dr));
   c_rdf: cover property ($rose(r.rx_fill_flag));
   c_tx_drop: cover property (r.room && !tx_acc_ok && wb_we_i && req);
endmodule // uart_fifo_status_flags
